//--- design/ishi_map.svh
`ifndef ISHI_MAP_SVH
`define ISHI_MAP_SVH
`define ISHI_IO_PORT_W 3
`define ISHI_IO_MATCH_LO 4
`define ISHI_MEM_LO 12
`define ISHI_MEM_MATCH_W 8
`define ISHI_BOOT_MATCH_W 4
`define ISHI_BURST_NS 32000
`define ISHI_CLK_NS 25
`define ISHI_BURST_CYC (`ISHI_BURST_NS / `ISHI_CLK_NS)
`define ISHI_IRQ_SEL_W 2
`define ISHI_DMA_SEL_W 2
`define ISHI_NUM_IRQ 4
`define ISHI_NUM_DMA 3
`define ISHI_DMA_CNT_W 11
`endif

//--- design/ishi_pkg.sv
package ishi_pkg;
    typedef enum logic [1:0] {ISHI_DMA_IDLE, ISHI_DMA_REQ, ISHI_DMA_XFER} ishi_dma_state_t;
    typedef enum logic [1:0] {ISHI_W_IDLE, ISHI_W_LOW, ISHI_W_WIDE} ishi_width_state_t;
endpackage : ishi_pkg

//--- design/ishi_sel_if.sv
`timescale 1ns/1ps
// Carries a one-of-N select and its level from the main block to the driver.
interface ishi_sel_if #(parameter int N = 4);
    logic [1:0] sel;
    logic level;
    logic [N-1:0] pin_out;
    logic [N-1:0] pin_oe;
    modport ctrl (output sel, output level, input pin_out, input pin_oe);
    modport drv (input sel, input level, output pin_out, output pin_oe);
endinterface : ishi_sel_if

//--- design/ishi_sel_drv.sv
`timescale 1ns/1ps
// Drives the selected one of N three-state pins; every other pin stays released.
module ishi_sel_drv #(
    parameter int N = 4
) (
    ishi_sel_if.drv s // Select, level and pin drives.
);
    // Only the chosen pin is enabled, so unused board lines float as required.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            s.pin_oe[i] = (int'(s.sel) == i);
            s.pin_out[i] = (int'(s.sel) == i) && s.level;
        end
    end
endmodule : ishi_sel_drv

//--- design/ishi_host_if.sv
`timescale 1ns/1ps
`include "ishi_map.svh"
// Slave-side host bus port: decode, chip selects, data, interrupt and DMA pins.
// Functional notes
// - Memory 16-bit select low on own memory address in 16-bit mode, memory mode and enable set, external select low.
// - While refresh is low, reads, writes and DMA acknowledges are ignored.
// - I/O read of decoded address drives that 16-bit register onto data.
// - I/O write of decoded address stores data into that register.
// - I/O 16-bit select low on own I/O address in 16-bit mode, released otherwise.
// - Ready pulled low to stretch reads only while ready-disable is clear.
// - After reset the port works 8 bits wide until the enable toggle.
// - In 16-bit mode, low byte-high enable means the transfer uses data bits 8 to 15.
// - Interrupt goes high on event, low after status queue reads zero.
// - One of four interrupt pins active, others high impedance.
// - One of three DMA request pins active high for select 0 to 2, others high impedance; select 3 leaves all three released.
// - External select input used for memory decode only, ignored otherwise.
// - Boot memory select low on a memory read of a decoded boot memory address, outside refresh.
// - Bus status low on receive access, or follows host level when enabled.
// - No I/O response while address enable is high.
// - Sixteen I/O bytes decoded as eight 16-bit ports on address 0 to 15.
// - Interrupt pin chosen by a configuration value 0 to 3.
// - DMA request rises on waiting frames; falls at done or 32 us burst.
module ishi_host_if
    import ishi_pkg::*;
(
    input wire logic sys_clk, // 40 MHz clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic [19:0] sa, // System address.
    input wire logic [15:0] sd_in, // System data in.
    output logic [15:0] sd_out, // System data out.
    output logic sd_oe, // System data output enable.
    input wire logic aen, // DMA controller owns bus.
    input wire logic memr_n, // Memory read.
    input wire logic memw_n, // Memory write.
    input wire logic ior_n, // I/O read.
    input wire logic iow_n, // I/O write.
    input wire logic refresh_n, // Refresh cycle in progress.
    input wire logic sbhe_n, // Byte-high enable.
    input wire logic ext_decode_select_n, // External memory decode.
    input wire logic [2:0] dma_ack_in, // DMA acknowledges, active low.
    output logic mem_cs16_n_out, // Memory 16-bit select level.
    output logic mem_cs16_oe, // Memory 16-bit select enable.
    output logic io_cs16_n_out, // I/O 16-bit select level.
    output logic io_cs16_oe, // I/O 16-bit select enable.
    output logic chan_ready_out, // Channel ready level.
    output logic chan_ready_oe, // Channel ready enable.
    output logic boot_rom_select_n, // Boot memory select.
    output logic bus_activity_out_n, // Bus status level.
    output logic [3:0] irq_out, // Interrupt request levels.
    output logic [3:0] irq_oe, // Interrupt request enables.
    output logic [2:0] dma_req_out, // DMA request levels.
    output logic [2:0] dma_req_oe, // DMA request enables.
    input wire logic [15:0] io_base, // I/O base address.
    input wire logic [7:0] mem_base, // Memory base, address bits 19:12.
    input wire logic [3:0] boot_base, // Boot memory base, bits 19:16.
    input wire logic mem_mode, // Memory mode selected.
    input wire logic mem_space_enable, // Memory space enable.
    input wire logic ready_disable, // Channel ready disable.
    input wire logic host_ctrl1_enable, // Bus status under host control.
    input wire logic host_ctrl1_level, // Host bus status level.
    input wire logic dma_burst_mode, // DMA burst limit.
    input wire logic [1:0] irq_select, // Interrupt pin choice.
    input wire logic [1:0] dma_select, // DMA channel choice.
    input wire logic rx_access, // Receive activity bus access.
    input wire logic irq_event, // Interrupt event present, pulse.
    input wire logic isq_read_zero, // Status queue read as zero, pulse.
    input wire logic frames_waiting, // Received frames await DMA.
    input wire logic dma_done, // DMA operation complete, pulse.
    input wire logic rd_ready, // Internal read data ready.
    input wire logic [15:0] io_rd_data [8], // Port read data.
    output logic [2:0] io_port, // Addressed port.
    output logic [15:0] io_wr_data, // Write data.
    output logic io_wr_strobe, // Write pulse.
    output logic [1:0] io_wr_bytes, // Byte lanes written.
    output logic wide_mode // 16-bit mode active.
);
    // Decode terms, read path state and the two small state machines.
    logic refresh_ok, io_hit, mem_hit, io_rd, io_wr, mem_rd;
    logic iow_seen_ff, nxt_iow_seen;
    logic [15:0] rd_data_ff, nxt_rd_data;
    logic irq_lvl_ff, nxt_irq_lvl;
    ishi_width_state_t wst_ff, nxt_wst;
    ishi_dma_state_t dst_ff, nxt_dst;
    logic [`ISHI_DMA_CNT_W-1:0] dcnt_ff, nxt_dcnt;

    // Address decode; refresh masks every strobe and acknowledge.
    // The 16-bit select decode ignores refresh on purpose, so only the strobes, the acknowledge and the boot select carry the mask.
    assign refresh_ok = refresh_n;
    assign io_hit = !aen && (sa[15:`ISHI_IO_MATCH_LO] == io_base[15:`ISHI_IO_MATCH_LO]);
    assign mem_hit = mem_mode && mem_space_enable && !ext_decode_select_n
        && (sa[19:`ISHI_MEM_LO] == mem_base);
    assign io_rd = io_hit && !ior_n && refresh_ok;
    assign io_wr = io_hit && !iow_n && refresh_ok;
    assign mem_rd = mem_hit && !memr_n && refresh_ok;
    // The port index is the word address inside the sixteen-byte window.
    assign io_port = sa[`ISHI_IO_PORT_W:1];

    // The 16-bit chip selects are open drain: enable low only on a hit.
    // Both selects stay off in 8-bit mode, so the host keeps to byte cycles.
    assign io_cs16_n_out = 1'b0;
    assign io_cs16_oe = io_hit && wide_mode;
    assign mem_cs16_n_out = 1'b0;
    assign mem_cs16_oe = mem_hit && wide_mode;
    assign boot_rom_select_n = !(!memr_n && refresh_ok
        && sa[19:16] == boot_base[`ISHI_BOOT_MATCH_W-1:0]);
    // Ready stretches reads until internal data is ready; the disable wins.
    // Memory reads stretch on the same internal ready as I/O reads, a known limitation.
    assign chan_ready_out = 1'b0;
    assign chan_ready_oe = !ready_disable && (io_rd || mem_rd) && !rd_ready;
    // Data is driven only during a decoded read; in 8-bit mode all 16 lanes are driven, the high lane with zero on even addresses.
    assign sd_out = rd_data_ff;
    assign sd_oe = io_rd || mem_rd;
    // Bus status is active low and follows the host level while the host holds control.
    assign bus_activity_out_n = host_ctrl1_enable ? !host_ctrl1_level : !rx_access;

    // Register read data and detect the write edge once per cycle.
    always_comb begin
        nxt_rd_data = io_rd_data[io_port];
        if (!wide_mode || sbhe_n) begin
            nxt_rd_data[15:8] = sa[0] ? io_rd_data[io_port][15:8] : 8'h00;
            if (sa[0]) nxt_rd_data[7:0] = io_rd_data[io_port][15:8];
        end
        nxt_iow_seen = io_wr;
    end
    // Read data is registered so the data pins never glitch while the address settles.
    // The cost is one cycle of latency, which the ready stretch does not cover, as it follows rd_ready alone.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_ff <= 16'h0000;
            iow_seen_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            iow_seen_ff <= nxt_iow_seen;
        end
    end
    // Write commits on the first cycle of a decoded write.
    assign io_wr_strobe = io_wr && !iow_seen_ff;
    assign io_wr_data = (wide_mode && !sbhe_n) ? sd_in : {sd_in[7:0], sd_in[7:0]};
    assign io_wr_bytes = (wide_mode && !sbhe_n) ? (sa[0] ? 2'b10 : 2'b11)
        : (sa[0] ? 2'b10 : 2'b01);

    // Width entry: byte-high enable must go low then high after reset.
    always_comb begin
        nxt_wst = wst_ff;
        case (wst_ff)
            ISHI_W_IDLE: if (!sbhe_n) nxt_wst = ISHI_W_LOW;
            ISHI_W_LOW: if (sbhe_n) nxt_wst = ISHI_W_WIDE;
            ISHI_W_WIDE: nxt_wst = ISHI_W_WIDE;
            default: nxt_wst = ISHI_W_IDLE;
        endcase
    end
    // Any reset drops the port back to 8-bit width until the toggle is seen again.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) wst_ff <= ISHI_W_IDLE;
        else wst_ff <= nxt_wst;
    end
    // Wide mode is decoded from the registered state, so it never glitches.
    assign wide_mode = (wst_ff == ISHI_W_WIDE);

    // Interrupt level: a new event wins over a same-cycle empty queue read.
    // Losing an event here would leave the host waiting on a silent line.
    always_comb begin
        nxt_irq_lvl = irq_lvl_ff;
        if (isq_read_zero) nxt_irq_lvl = 1'b0;
        if (irq_event) nxt_irq_lvl = 1'b1;
    end
    // The level clears only through reset or an empty queue read.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) irq_lvl_ff <= 1'b0;
        else irq_lvl_ff <= nxt_irq_lvl;
    end

    // DMA request; acknowledge is taken only from the selected channel.
    always_comb begin
        logic ack;
        // Select value three names no channel, so no acknowledge can start a transfer.
        ack = refresh_ok && (dma_select < `ISHI_DMA_SEL_W'(`ISHI_NUM_DMA))
            && !dma_ack_in[dma_select];
        nxt_dst = dst_ff;
        nxt_dcnt = dcnt_ff;
        case (dst_ff)
            ISHI_DMA_IDLE: if (frames_waiting) nxt_dst = ISHI_DMA_REQ;
            ISHI_DMA_REQ: if (ack) begin
                nxt_dst = ISHI_DMA_XFER;
                nxt_dcnt = '0;
            end
            ISHI_DMA_XFER: begin
                if (dcnt_ff != `ISHI_DMA_CNT_W'(`ISHI_BURST_CYC)) nxt_dcnt = dcnt_ff + 1'b1;
                // A done pulse ends the transfer at once, in burst mode as well.
                if (dma_done) nxt_dst = ISHI_DMA_IDLE;
                else if (dma_burst_mode && dcnt_ff == `ISHI_DMA_CNT_W'(`ISHI_BURST_CYC - 1))
                    nxt_dst = ISHI_DMA_IDLE;
            end
            default: nxt_dst = ISHI_DMA_IDLE;
        endcase
    end
    // The burst counter saturates, so a late done pulse cannot wrap it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dst_ff <= ISHI_DMA_IDLE;
            dcnt_ff <= '0;
        end else begin
            dst_ff <= nxt_dst;
            dcnt_ff <= nxt_dcnt;
        end
    end

    // One-of-N pin drivers for interrupt and DMA request.
    ishi_sel_if #(.N(`ISHI_NUM_IRQ)) irq_s ();
    ishi_sel_if #(.N(`ISHI_NUM_DMA)) dma_s ();
    assign irq_s.sel = irq_select;
    assign irq_s.level = irq_lvl_ff;
    assign dma_s.sel = dma_select;
    assign dma_s.level = (dst_ff != ISHI_DMA_IDLE);
    ishi_sel_drv #(.N(`ISHI_NUM_IRQ)) u_irq (.s(irq_s.drv));
    ishi_sel_drv #(.N(`ISHI_NUM_DMA)) u_dma (.s(dma_s.drv));
    // The pin arrays pass straight out; the enables mark which pins are driven.
    assign irq_out = irq_s.pin_out;
    assign irq_oe = irq_s.pin_oe;
    assign dma_req_out = dma_s.pin_out;
    assign dma_req_oe = dma_s.pin_oe;
endmodule : ishi_host_if

//--- verif/ishi_host_dma_model.sv
`timescale 1ns/1ps
// Host DMA controller model: acknowledges the live request after a short or long delay.
module ishi_host_dma_model (
    input wire logic sys_clk, // Bus clock.
    input wire logic [2:0] dma_req_out, // Request levels.
    input wire logic [2:0] dma_req_oe, // Request enables.
    input wire logic slow, // Long acknowledge delay.
    output logic [2:0] dma_ack_in // Acknowledges, active low.
);
    int cnt = 0;
    initial dma_ack_in = 3'h7;
    // Only a driven request is answered, on its own lane, so a wrong lane shows up.
    always @(posedge sys_clk) begin
        cnt <= (|(dma_req_out & dma_req_oe)) ? cnt + 1 : 0;
        dma_ack_in <= (cnt >= (slow ? 6 : 1)) ? ~(dma_req_out & dma_req_oe) : 3'h7;
    end
endmodule : ishi_host_dma_model

//--- verif/ishi_host_if_chk.sv
`timescale 1ns/1ps
// Watches the host port pins; all relations are sampled on the bus clock.
module ishi_host_if_chk (
    input wire logic sys_clk, // Bus clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic aen, // DMA controller owns bus.
    input wire logic memr_n, // Memory read.
    input wire logic ior_n, // I/O read.
    input wire logic iow_n, // I/O write.
    input wire logic refresh_n, // Refresh cycle.
    input wire logic ext_decode_select_n, // External memory decode.
    input wire logic mem_mode, // Memory mode.
    input wire logic mem_space_enable, // Memory space enable.
    input wire logic ready_disable, // Ready disable.
    input wire logic host_ctrl1_enable, // Host owns bus status.
    input wire logic host_ctrl1_level, // Host bus status level.
    input wire logic rx_access, // Receive bus access.
    input wire logic irq_event, // Interrupt event.
    input wire logic isq_read_zero, // Empty queue read.
    input wire logic wide_mode, // 16-bit mode.
    input wire logic sd_oe, // Data enable.
    input wire logic io_wr_strobe, // Write pulse.
    input wire logic io_cs16_oe, // I/O select enable.
    input wire logic io_cs16_n_out, // I/O select level.
    input wire logic mem_cs16_oe, // Memory select enable.
    input wire logic mem_cs16_n_out, // Memory select level.
    input wire logic chan_ready_oe, // Ready enable.
    input wire logic chan_ready_out, // Ready level.
    input wire logic boot_rom_select_n, // Boot memory select.
    input wire logic bus_activity_out_n, // Bus status.
    input wire logic [19:0] sa, // Address.
    input wire logic [15:0] io_base, // I/O base.
    input wire logic [7:0] mem_base, // Memory base.
    input wire logic [3:0] boot_base, // Boot base.
    input wire logic [3:0] irq_out, // Interrupt levels.
    input wire logic [3:0] irq_oe, // Interrupt enables.
    input wire logic [1:0] irq_select, // Interrupt choice.
    input wire logic [1:0] dma_select, // DMA choice.
    input wire logic [2:0] dma_req_oe // Request enables.
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_IO_CS16: assert property ((io_cs16_oe == (!aen && sa[15:4] == io_base[15:4] && wide_mode))
        && (!io_cs16_oe || !io_cs16_n_out)) else $error("io select wrong");
    AST_MEM_CS16: assert property (mem_cs16_oe == (mem_mode && mem_space_enable && wide_mode
        && !ext_decode_select_n && sa[19:12] == mem_base)) else $error("mem select wrong");
    AST_WR_STROBE: assert property (io_wr_strobe |-> (!iow_n && refresh_n && !aen
        && sa[15:4] == io_base[15:4]) ##1 !io_wr_strobe) else $error("bad write");
    AST_SD_OE: assert property (sd_oe |-> refresh_n && (!ior_n || !memr_n))
        else $error("data driven outside read");
    AST_READY: assert property (chan_ready_oe |-> !ready_disable && sd_oe && !chan_ready_out)
        else $error("ready wrong");
    AST_BOOT: assert property (boot_rom_select_n == !(!memr_n && refresh_n
        && sa[19:16] == boot_base)) else $error("boot select wrong");
    AST_BUS: assert property (bus_activity_out_n == (host_ctrl1_enable ? !host_ctrl1_level
        : !rx_access)) else $error("bus status wrong");
    AST_IRQ_OE: assert property (irq_oe == 4'h1 << irq_select)
        else $error("irq enable wrong");
    AST_DMA_OE: assert property (dma_req_oe == (dma_select == 2'h3 ? 3'h0 : 3'h1 << dma_select))
        else $error("dma enable wrong");
    AST_IRQ_SET: assert property (irq_event |=> (irq_out & irq_oe) != 4'h0)
        else $error("irq not raised");
    AST_IRQ_CLR: assert property (isq_read_zero && !irq_event |=> (irq_out & irq_oe) == 4'h0)
        else $error("irq not cleared");
    AST_RST_WIDE: assert property ($rose(arst_n) |-> !wide_mode)
        else $error("wide after reset");
endmodule : ishi_host_if_chk
bind ishi_host_if ishi_host_if_chk i_ishi_host_if_chk (.*);

//--- verif/test_ishi_host_if.sv
`timescale 1ns/1ps
module test_ishi_host_if;
    import ishi_pkg::*;
    typedef struct packed {logic [19:0] a; logic [3:0] c; logic [2:0] e;} ishi_row_t;
    logic sys_clk = 0, arst_n = 0, aen = 0, memr_n = 1, memw_n = 1, ior_n = 1, iow_n = 1;
    logic refresh_n = 1, sbhe_n = 1, ext_decode_select_n = 1, mem_mode = 0, mem_space_enable = 0;
    logic ready_disable = 0, host_ctrl1_enable = 0, host_ctrl1_level = 0, dma_burst_mode = 0;
    logic rx_access = 0, irq_event = 0, isq_read_zero = 0, frames_waiting = 0, dma_done = 0;
    logic rd_ready = 1, slow = 0;
    logic [19:0] sa = 20'h0;
    logic [15:0] sd_in = 16'h0, io_base = 16'h0300, sd_out, io_wr_data;
    logic [15:0] io_rd_data [8];
    logic [7:0] mem_base = 8'hd0;
    logic [3:0] boot_base = 4'hc, irq_out, irq_oe;
    logic [2:0] dma_req_out, dma_req_oe, dma_ack_in, io_port;
    logic [1:0] irq_select = 2'h2, dma_select = 2'h1, io_wr_bytes;
    logic sd_oe, mem_cs16_n_out, mem_cs16_oe, io_cs16_n_out, io_cs16_oe, chan_ready_out;
    logic chan_ready_oe, boot_rom_select_n, bus_activity_out_n, io_wr_strobe, wide_mode;
    int num_errors = 0, n_checks = 0, k;
    // Rows: address, {ior_n, iow_n, refresh_n, aen}, expected {sd_oe, strobe, io select}.
    ishi_row_t rows [7] = '{'{20'h00302, 4'h6, 3'h5}, '{20'h00304, 4'ha, 3'h3},
        '{20'h00306, 4'h4, 3'h1}, '{20'h00308, 4'hb, 3'h0}, '{20'h00312, 4'h6, 3'h0},
        '{20'h0030e, 4'ha, 3'h3}, '{20'h002fe, 4'h6, 3'h0}};
    // Free-running bus clock.
    always #12.5 sys_clk = ~sys_clk;
    ishi_host_if i_ishi_host_if (.*);
    ishi_host_dma_model i_ishi_host_dma_model (.*);
    // Compares one value against its expectation.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Prints the verdict and stops.
    task end_of_test;
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Reset, width entry, row loop, then the awkward cases.
    initial begin
        for (int i = 0; i < 8; i++) io_rd_data[i] = {8'ha5, 8'(i)};
        repeat (3) @(posedge sys_clk);
        chk({wide_mode, irq_out, dma_req_out, sd_out}, 0);
        arst_n <= 1'b1;
        sa <= 20'h00302;
        ior_n <= 1'b0;
        sbhe_n <= 1'b0;
        @(negedge sys_clk) chk(io_cs16_oe, 0);
        @(posedge sys_clk) {ior_n, sbhe_n} <= 2'b11;
        @(posedge sys_clk) sbhe_n <= 1'b0;
        @(negedge sys_clk) chk(wide_mode, 1);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            sa <= rows[i].a;
            {ior_n, iow_n, refresh_n, aen} <= rows[i].c;
            sd_in <= {12'h5a3, rows[i].a[3:0]};
            @(negedge sys_clk) chk({sd_oe, io_wr_strobe, io_cs16_oe}, rows[i].e);
            if (rows[i].e[1]) chk({io_port, io_wr_bytes, io_wr_data},
                {rows[i].a[3:1], 2'h3, 12'h5a3, rows[i].a[3:0]});
            @(negedge sys_clk) if (rows[i].e[2]) chk(sd_out, io_rd_data[rows[i].a[3:1]]);
            @(posedge sys_clk) {ior_n, iow_n, refresh_n, aen} <= 4'he;
        end
        // A stalled read stretches the cycle only while ready is enabled.
        @(posedge sys_clk) {sa, ior_n, rd_ready} <= {20'h00302, 2'b00};
        @(negedge sys_clk) chk({chan_ready_oe, chan_ready_out}, 2'b10);
        @(posedge sys_clk) ready_disable <= 1'b1;
        @(negedge sys_clk) chk(chan_ready_oe, 0);
        @(posedge sys_clk) {ior_n, rd_ready, mem_mode, mem_space_enable} <= 4'hf;
        {ext_decode_select_n, sa} <= {1'b0, 20'hd0010};
        @(negedge sys_clk) chk({mem_cs16_oe, mem_cs16_n_out}, 2'b10);
        @(posedge sys_clk) mem_space_enable <= 1'b0;
        @(negedge sys_clk) chk(mem_cs16_oe, 0);
        @(posedge sys_clk) {sa, memr_n} <= {20'hc1234, 1'b0};
        @(negedge sys_clk) chk(boot_rom_select_n, 0);
        @(posedge sys_clk) refresh_n <= 1'b0;
        @(negedge sys_clk) chk(boot_rom_select_n, 1);
        @(posedge sys_clk) {memr_n, refresh_n, rx_access} <= 3'h7;
        for (k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            {host_ctrl1_enable, host_ctrl1_level} <= 2'(k);
            irq_select <= 2'(k);
            dma_select <= 2'(k);
            @(negedge sys_clk) chk(bus_activity_out_n, k[1] ? !k[0] : 0);
            chk(irq_oe, 4'h1 << k);
            chk(dma_req_oe, k == 3 ? 3'h0 : 3'h1 << k);
        end
        // Without host control and without receive access the status line is idle high.
        @(posedge sys_clk) {host_ctrl1_enable, rx_access} <= 2'b00;
        @(negedge sys_clk) chk(bus_activity_out_n, 1);
        // Interrupt raise and clear, with a burst DMA started alongside.
        @(posedge sys_clk) {irq_event, dma_select, dma_burst_mode, frames_waiting} <= 5'h17;
        @(posedge sys_clk) irq_event <= 1'b0;
        @(negedge sys_clk) chk(irq_out & irq_oe, 4'h8);
        @(posedge sys_clk) isq_read_zero <= 1'b1;
        @(posedge sys_clk) isq_read_zero <= 1'b0;
        @(negedge sys_clk) chk({irq_out, dma_req_out & dma_req_oe}, 7'h02);
        @(posedge sys_clk) frames_waiting <= 1'b0;
        for (k = 0; k < 1400 && dma_req_out[1] === 1'b1; k++) @(negedge sys_clk);
        chk(k > 1270 && k < 1300, 1);
        if (k == 1400) end_of_test();
        // Completion-ended DMA with a slow acknowledge.
        @(posedge sys_clk) {dma_burst_mode, slow, frames_waiting} <= 3'h3;
        repeat (12) @(posedge sys_clk);
        frames_waiting <= 1'b0;
        @(negedge sys_clk) chk({dma_req_out[1], dma_ack_in}, 4'hd);
        @(posedge sys_clk) dma_done <= 1'b1;
        @(posedge sys_clk) dma_done <= 1'b0;
        @(negedge sys_clk) chk(dma_req_out[1], 0);
        @(posedge sys_clk) {arst_n, sbhe_n} <= 2'b01;
        @(negedge sys_clk) chk(wide_mode, 0);
        // A second release: the port is 8 bits wide again and odd bytes travel on the low data lane.
        @(posedge sys_clk) arst_n <= 1'b1;
        @(posedge sys_clk) {sa, iow_n, sd_in} <= {20'h00303, 1'b0, 16'h00c3};
        @(negedge sys_clk) chk({wide_mode, io_cs16_oe, io_wr_strobe, io_wr_bytes, io_wr_data},
            {3'h1, 2'h2, 16'hc3c3});
        @(posedge sys_clk) {iow_n, ior_n} <= 2'b10;
        @(negedge sys_clk) chk(sd_oe, 1);
        @(negedge sys_clk) chk(sd_out[7:0], 8'ha5);
        end_of_test();
    end
endmodule : test_ishi_host_if
